// ### verilog/regulator_discharge_map.svh
// Register offsets, field positions and reset values of the discharge and fault register bank
`ifndef REGULATOR_DISCHARGE_MAP_SVH
`define REGULATOR_DISCHARGE_MAP_SVH

`define ADDR_W            8
`define DATA_W            32
`define REG_W             8

// Byte addresses on the APB
`define OFS_OUTPUT_CTRL   8'h00
`define OFS_FAULT_ONE     8'h04
`define OFS_FAULT_TWO     8'h08
`define OFS_MASK_ONE      8'h0C
`define OFS_MASK_TWO      8'h10

// Output control fields
`define CTRL_PASS_BIT     6
`define CTRL_LVL3_HI      5
`define CTRL_LVL3_LO      4
`define CTRL_LVL2_HI      3
`define CTRL_LVL2_LO      2
`define CTRL_LVL1_HI      1
`define CTRL_LVL1_LO      0
`define CTRL_RW_MASK      8'h7F
`define CTRL_RESET        8'h00

// Fault status one: bits 5..0 hold stepdown 6..1 low flags
`define FLT1_W            6
`define FLT1_SIXTH_BIT    5
`define FLT1_FIFTH_BIT    4
`define FLT1_FOURTH_BIT   3
`define FLT1_THIRD_BIT    2
`define FLT1_SECOND_BIT   1
`define FLT1_RESET        6'h00

// Fault status two: supply good loss at 3, linear regs 3..1 at 2..0
`define FLT2_W            4
`define FLT2_SUPPLY_BIT   3
`define FLT2_RESET        4'h0

`define LANE0_STRB        0
`define ZERO_BYTE         8'h00
`define ZERO_WORD         32'h00000000

`endif

// ### verilog/regulator_discharge_pkg.sv
// Types shared by the discharge and fault register bank
package regulator_discharge_pkg;
   `include "regulator_discharge_map.svh"

   typedef enum logic [1:0] {
      DRAIN_OFF    = 2'h0,
      DRAIN_SLOW   = 2'h1,
      DRAIN_MEDIUM = 2'h2,
      DRAIN_FAST   = 2'h3
   } drain_level_e;

   typedef struct packed {
      logic         third_linear_reg_passthrough;
      drain_level_e third_linear_reg_drain_level;
      drain_level_e second_linear_reg_drain_level;
      drain_level_e first_linear_reg_drain_level;
   } output_cfg_s;

   typedef struct packed {
      logic [5:0] stepdown_low;
      logic [2:0] linear_low;
      logic       supply_good_loss;
   } fault_event_s;

   typedef enum logic [1:0] {
      ST_IDLE   = 2'b01,
      ST_ANSWER = 2'b10
   } access_state_e;
endpackage

// ### verilog/apb_access_ctl.sv
// APB access sequencer: one wait state, then the completing cycle
module apb_access_ctl
   import regulator_discharge_pkg::*;
(
   input  wire logic clk_sys,   // System clock
   input  wire logic rst,       // Async reset, high
   input  wire logic ce,        // Clock enable
   input  wire logic psel,      // APB select
   input  wire logic penable,   // APB enable
   output logic      pready,    // APB ready
   output logic      load,      // Capture read data
   output logic      complete   // Transfer ends this edge
);
   access_state_e state_q;

   assign load     = ce && psel && penable && (state_q == ST_IDLE);
   assign complete = ce && psel && penable && (state_q == ST_ANSWER);
   // Ready withheld while frozen, so a stalled write is never lost
   assign pready   = ce && (state_q == ST_ANSWER);

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state_q <= ST_IDLE;
      end else if (ce) begin
         case (state_q)
            ST_IDLE:   if (psel && penable) state_q <= ST_ANSWER;
            ST_ANSWER: state_q <= ST_IDLE;
            default:   state_q <= ST_IDLE;
         endcase
      end
   end
endmodule

// ### verilog/sticky_flag_bank.sv
// Write-one-to-clear sticky flags with interrupt mask gating
module sticky_flag_bank
   import regulator_discharge_pkg::*;
#(
   parameter int W = 1
) (
   input  wire logic         clk_sys,  // System clock
   input  wire logic         rst,      // Async reset, high
   input  wire logic         ce,       // Clock enable
   input  wire logic [W-1:0] set,      // Fault events
   input  wire logic [W-1:0] clr,      // Write-one clear strobes
   input  wire logic [W-1:0] mask,     // Interrupt enables
   output logic      [W-1:0] flag_q,   // Latched flags
   output logic              pend      // Unmasked flag present
);
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_flag
         always_ff @(posedge clk_sys or posedge rst) begin
            if (rst) begin
               flag_q[i] <= 1'b0;
            end else if (ce) begin
               // Set beats a simultaneous clear
               flag_q[i] <= (flag_q[i] && !clr[i]) || set[i];
            end
         end
      end
   endgenerate

   assign pend = |(flag_q & mask);
endmodule

// ### verilog/regulator_discharge_regs.sv
// APB register bank: linear regulator output control and latched fault status
// What this block does
// [RULE1] Third regulator drain level at bits 5:4
// [RULE2] Second regulator drain level at bits 3:2
// [RULE3] First regulator drain level at bits 1:0
// [RULE4] Bit 5 latches sixth stepdown low, W1C
// [RULE5] Bit 4 latches fifth stepdown low, W1C
// [RULE6] Bit 3 latches fourth stepdown low, W1C
// [RULE7] Bit 2 latches third stepdown low, W1C
// [RULE8] Second stepdown low flag latched, W1C
// [RULE9] Next status bits 3:0 latch supply, linears
// [RULE10] Zero writes keep flags; set beats clear
//
// Local design decisions: the placing of the registers and register access over APB.
module regulator_discharge_regs
   import regulator_discharge_pkg::*;
(
   input  wire logic                 clk_sys,     // System clock, 20 MHz
   input  wire logic                 rst,         // Async reset, high
   input  wire logic                 ce,          // Clock enable, freezes state
   input  wire logic                 psel,        // APB select
   input  wire logic                 penable,     // APB enable
   input  wire logic                 pwrite,      // APB write
   input  wire logic [`ADDR_W-1:0]   paddr,       // APB byte address
   input  wire logic [`DATA_W-1:0]   pwdata,      // APB write data
   input  wire logic [3:0]           pstrb,       // APB byte strobes
   output logic                      pready,      // APB ready
   output logic      [`DATA_W-1:0]   prdata,      // APB read data
   output logic                      pslverr,     // APB error, unmapped
   input  wire fault_event_s         fault_in,    // Fault detector pulses
   output output_cfg_s               out_cfg,     // Regulator output settings
   output logic                      irq          // Unmasked fault pending
);
   logic               load;
   logic               complete;
   logic               sel_ctrl;
   logic               sel_flt1;
   logic               sel_flt2;
   logic               sel_msk1;
   logic               sel_msk2;
   logic               mapped;
   logic               wr_lane0;
   logic [`REG_W-1:0]  ctrl_q;
   logic [`REG_W-1:0]  rd_mux;
   logic [`FLT1_W-1:0] flt1_q;
   logic [`FLT2_W-1:0] flt2_q;
   logic [`FLT1_W-1:0] msk1_q;
   logic [`FLT2_W-1:0] msk2_q;
   logic [`FLT1_W-1:0] clr1;
   logic [`FLT2_W-1:0] clr2;
   logic [`FLT1_W-1:0] set1;
   logic [`FLT2_W-1:0] set2;
   logic               pend1;
   logic               pend2;
   logic [`DATA_W-1:0] prdata_q;
   logic               pslverr_q;

   apb_access_ctl u_access (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .ce       (ce),
      .psel     (psel),
      .penable  (penable),
      .pready   (pready),
      .load     (load),
      .complete (complete)
   );

   // Address decode
   assign sel_ctrl = (paddr == `OFS_OUTPUT_CTRL);
   assign sel_flt1 = (paddr == `OFS_FAULT_ONE);
   assign sel_flt2 = (paddr == `OFS_FAULT_TWO);
   assign sel_msk1 = (paddr == `OFS_MASK_ONE);
   assign sel_msk2 = (paddr == `OFS_MASK_TWO);
   assign mapped   = sel_ctrl || sel_flt1 || sel_flt2 || sel_msk1 || sel_msk2;

   // Writes land only at the completing edge, low byte lane only
   assign wr_lane0 = complete && pwrite && pstrb[`LANE0_STRB];

   // Output control register
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ctrl_q <= `CTRL_RESET;
      end else if (wr_lane0 && sel_ctrl) begin
         ctrl_q <= pwdata[`REG_W-1:0] & `CTRL_RW_MASK;
      end
   end

   assign out_cfg.third_linear_reg_passthrough  = ctrl_q[`CTRL_PASS_BIT];
   assign out_cfg.third_linear_reg_drain_level  =
      drain_level_e'(ctrl_q[`CTRL_LVL3_HI:`CTRL_LVL3_LO]); // [RULE1]
   assign out_cfg.second_linear_reg_drain_level =
      drain_level_e'(ctrl_q[`CTRL_LVL2_HI:`CTRL_LVL2_LO]); // [RULE2]
   assign out_cfg.first_linear_reg_drain_level  =
      drain_level_e'(ctrl_q[`CTRL_LVL1_HI:`CTRL_LVL1_LO]); // [RULE3]

   // Mask registers
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         msk1_q <= `FLT1_RESET;
      end else if (wr_lane0 && sel_msk1) begin
         msk1_q <= pwdata[`FLT1_W-1:0];
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         msk2_q <= `FLT2_RESET;
      end else if (wr_lane0 && sel_msk2) begin
         msk2_q <= pwdata[`FLT2_W-1:0];
      end
   end

   // Clear strobes: only written ones clear
   assign clr1 = (wr_lane0 && sel_flt1) ? pwdata[`FLT1_W-1:0] : `FLT1_RESET; // [RULE10]
   assign clr2 = (wr_lane0 && sel_flt2) ? pwdata[`FLT2_W-1:0] : `FLT2_RESET; // [RULE10]

   // Event routing into the status layouts
   assign set1 = fault_in.stepdown_low; // [RULE4] [RULE5] [RULE6] [RULE7] [RULE8]
   assign set2 = {fault_in.supply_good_loss, fault_in.linear_low}; // [RULE9]

   sticky_flag_bank #(
      .W (`FLT1_W)
   ) u_flt1 (
      .clk_sys (clk_sys),
      .rst     (rst),
      .ce      (ce),
      .set     (set1),
      .clr     (clr1),
      .mask    (msk1_q),
      .flag_q  (flt1_q),
      .pend    (pend1)
   );

   sticky_flag_bank #(
      .W (`FLT2_W)
   ) u_flt2 (
      .clk_sys (clk_sys),
      .rst     (rst),
      .ce      (ce),
      .set     (set2),
      .clr     (clr2),
      .mask    (msk2_q),
      .flag_q  (flt2_q),
      .pend    (pend2)
   );

   assign irq = pend1 || pend2;

   // Read mux, unused bits read zero
   always_comb begin
      rd_mux = `ZERO_BYTE;
      case (1'b1)
         sel_ctrl: rd_mux = ctrl_q;
         sel_flt1: rd_mux = {{(`REG_W-`FLT1_W){1'b0}}, flt1_q};
         sel_flt2: rd_mux = {{(`REG_W-`FLT2_W){1'b0}}, flt2_q};
         sel_msk1: rd_mux = {{(`REG_W-`FLT1_W){1'b0}}, msk1_q};
         sel_msk2: rd_mux = {{(`REG_W-`FLT2_W){1'b0}}, msk2_q};
         default:  rd_mux = `ZERO_BYTE;
      endcase
   end

   // Read data and error captured in the wait cycle
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         prdata_q <= `ZERO_WORD;
      end else if (load) begin
         prdata_q <= pwrite ? `ZERO_WORD : {{(`DATA_W-`REG_W){1'b0}}, rd_mux};
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pslverr_q <= 1'b0;
      end else if (load) begin
         pslverr_q <= !mapped;
      end
   end

   assign prdata  = prdata_q;
   assign pslverr = pslverr_q;

   // Checks
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   a_third_drain_field: // [RULE1]
      assert property ($past(wr_lane0 && sel_ctrl)
                       |-> out_cfg.third_linear_reg_drain_level
                           == drain_level_e'($past(pwdata[`CTRL_LVL3_HI:`CTRL_LVL3_LO])))
      else $error("third drain level not taken from bits 5:4");

   a_second_drain_field: // [RULE2]
      assert property ($past(wr_lane0 && sel_ctrl)
                       |-> out_cfg.second_linear_reg_drain_level
                           == drain_level_e'($past(pwdata[`CTRL_LVL2_HI:`CTRL_LVL2_LO])))
      else $error("second drain level not taken from bits 3:2");

   a_first_drain_field: // [RULE3]
      assert property ($past(wr_lane0 && sel_ctrl)
                       |-> out_cfg.first_linear_reg_drain_level
                           == drain_level_e'($past(pwdata[`CTRL_LVL1_HI:`CTRL_LVL1_LO])))
      else $error("first drain level not taken from bits 1:0");

   a_sixth_flag_sets: // [RULE4]
      assert property (ce && fault_in.stepdown_low[`FLT1_SIXTH_BIT]
                       |=> flt1_q[`FLT1_SIXTH_BIT])
      else $error("sixth stepdown low flag not set");

   a_fifth_flag_holds: // [RULE5]
      assert property (flt1_q[`FLT1_FIFTH_BIT] && !(wr_lane0 && sel_flt1
                       && pwdata[`FLT1_FIFTH_BIT])
                       |=> flt1_q[`FLT1_FIFTH_BIT])
      else $error("fifth stepdown low flag lost without clear");

   a_fourth_flag_clears: // [RULE6]
      assert property (wr_lane0 && sel_flt1 && pwdata[`FLT1_FOURTH_BIT]
                       && !fault_in.stepdown_low[`FLT1_FOURTH_BIT]
                       |=> !flt1_q[`FLT1_FOURTH_BIT])
      else $error("fourth stepdown low flag not cleared by one");

   a_third_flag_read: // [RULE7]
      assert property (load && !pwrite && sel_flt1
                       |=> prdata[`FLT1_THIRD_BIT] == $past(flt1_q[`FLT1_THIRD_BIT]) && (pready || !ce))
      else $error("third stepdown low flag misread");

   a_second_flag_sticky: // [RULE8]
      assert property (ce && fault_in.stepdown_low[`FLT1_SECOND_BIT] ##1
                       !(wr_lane0 && sel_flt1)[*2]
                       |=> flt1_q[`FLT1_SECOND_BIT])
      else $error("second stepdown low flag did not stay set");

   a_supply_flag_sets: // [RULE9]
      assert property (ce && fault_in.supply_good_loss
                       |=> flt2_q[`FLT2_SUPPLY_BIT])
      else $error("supply good loss flag not set");

   a_set_beats_clear: // [RULE10]
      assert property (wr_lane0 && sel_flt1 && ((set1 & clr1) != `FLT1_RESET)
                       |=> (flt1_q & $past(set1 & clr1)) == $past(set1 & clr1))
      else $error("clear won over a same-cycle fault event");

   a_zero_write_keeps: // [RULE10]
      assert property (wr_lane0 && sel_flt2
                       |=> (flt2_q & ~$past(pwdata[`FLT2_W-1:0]))
                           == (($past(flt2_q) | $past(set2)) & ~$past(pwdata[`FLT2_W-1:0])))
      else $error("zero write changed a latched flag");

   a_irq_tracks_mask:
      assert property (irq == (((flt1_q & msk1_q) != `FLT1_RESET)
                               || ((flt2_q & msk2_q) != `FLT2_RESET)))
      else $error("interrupt does not follow masked flags");

   a_ready_after_wait:
      assert property (load
                       |=> pready == ce)
      else $error("ready not raised after one wait cycle");

   a_ready_one_cycle:
      assert property (complete
                       |=> !pready)
      else $error("ready held past the completing cycle");

   a_fifth_flag_sets: // [RULE5]
      assert property (ce && fault_in.stepdown_low[`FLT1_FIFTH_BIT]
                       |=> flt1_q[`FLT1_FIFTH_BIT])
      else $error("fifth stepdown low flag not set");

   a_fourth_flag_sets: // [RULE6]
      assert property (ce && fault_in.stepdown_low[`FLT1_FOURTH_BIT]
                       |=> flt1_q[`FLT1_FOURTH_BIT])
      else $error("fourth stepdown low flag not set");

   a_third_flag_sets: // [RULE7]
      assert property (ce && fault_in.stepdown_low[`FLT1_THIRD_BIT]
                       |=> flt1_q[`FLT1_THIRD_BIT])
      else $error("third stepdown low flag not set");

   a_second_flag_sets: // [RULE8]
      assert property (ce && fault_in.stepdown_low[`FLT1_SECOND_BIT]
                       |=> flt1_q[`FLT1_SECOND_BIT])
      else $error("second stepdown low flag not set");

   a_sixth_flag_holds: // [RULE4]
      assert property (flt1_q[`FLT1_SIXTH_BIT] && !(wr_lane0 && sel_flt1 && pwdata[`FLT1_SIXTH_BIT])
                       |=> flt1_q[`FLT1_SIXTH_BIT])
      else $error("sixth stepdown low flag lost without clear");

   a_sixth_flag_clears: // [RULE4]
      assert property (wr_lane0 && sel_flt1 && pwdata[`FLT1_SIXTH_BIT]
                       && !fault_in.stepdown_low[`FLT1_SIXTH_BIT] |=> !flt1_q[`FLT1_SIXTH_BIT])
      else $error("sixth stepdown low flag not cleared by one");

   a_fifth_flag_clears: // [RULE5]
      assert property (wr_lane0 && sel_flt1 && pwdata[`FLT1_FIFTH_BIT]
                       && !fault_in.stepdown_low[`FLT1_FIFTH_BIT] |=> !flt1_q[`FLT1_FIFTH_BIT])
      else $error("fifth stepdown low flag not cleared by one");

   a_fourth_flag_holds: // [RULE6]
      assert property (flt1_q[`FLT1_FOURTH_BIT] && !(wr_lane0 && sel_flt1 && pwdata[`FLT1_FOURTH_BIT])
                       |=> flt1_q[`FLT1_FOURTH_BIT])
      else $error("fourth stepdown low flag lost without clear");

   a_third_flag_clears: // [RULE7]
      assert property (wr_lane0 && sel_flt1 && pwdata[`FLT1_THIRD_BIT]
                       && !fault_in.stepdown_low[`FLT1_THIRD_BIT] |=> !flt1_q[`FLT1_THIRD_BIT])
      else $error("third stepdown low flag not cleared by one");

   a_second_flag_clears: // [RULE8]
      assert property (wr_lane0 && sel_flt1 && pwdata[`FLT1_SECOND_BIT]
                       && !fault_in.stepdown_low[`FLT1_SECOND_BIT] |=> !flt1_q[`FLT1_SECOND_BIT])
      else $error("second stepdown low flag not cleared by one");

   a_status_two_sets: // [RULE9]
      assert property (ce
                       |=> (flt2_q & $past(set2)) == $past(set2))
      else $error("status two flag missed its event");

   a_status_two_clears: // [RULE9]
      assert property (wr_lane0 && sel_flt2
                       |=> (flt2_q & $past(pwdata[`FLT2_W-1:0] & ~set2)) == `FLT2_RESET)
      else $error("status two flag not cleared by one");

   a_status_one_keeps: // [RULE10]
      assert property (wr_lane0 && sel_flt1
                       |=> (flt1_q & ~$past(pwdata[`FLT1_W-1:0]))
                           == (($past(flt1_q) | $past(set1)) & ~$past(pwdata[`FLT1_W-1:0])))
      else $error("zero write changed a status one flag");

   a_ce_freezes_state:
      assert property (!ce
                       |=> $stable(ctrl_q) && $stable(flt1_q) && $stable(flt2_q) && $stable(prdata_q)
                           && $stable(pslverr_q) && $stable(msk1_q) && $stable(msk2_q))
      else $error("state moved while clock enable low");

   a_strobe_gates_write:
      assert property (complete && pwrite && !pstrb[`LANE0_STRB]
                       |=> $stable(ctrl_q) && $stable(msk1_q) && $stable(msk2_q))
      else $error("write without low lane strobe took effect");

   a_unmapped_error:
      assert property (load && !mapped
                       |=> pslverr && (prdata == `ZERO_WORD))
      else $error("unmapped access not refused");

   a_mapped_no_error:
      assert property (load && mapped
                       |=> !pslverr)
      else $error("mapped access flagged as error");

   a_write_reads_zero:
      assert property (load && pwrite
                       |=> prdata == `ZERO_WORD)
      else $error("write returned nonzero read data");
endmodule

// ### tb/tb_regulator_discharge_regs.sv
// Self-checking testbench for the discharge and fault register bank
`include "regulator_discharge_map.svh"
module tb_regulator_discharge_regs
   import regulator_discharge_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   logic         clk_sys, rst, ce, psel, penable, pwrite, pready, pslverr, irq, er;
   logic [7:0]   paddr;
   logic [31:0]  pwdata, prdata, rd, seed_q, v;
   logic [3:0]   pstrb;
   fault_event_s fault_in;
   output_cfg_s  out_cfg;
   int           miscompares, tests_run;

   regulator_discharge_regs u_dut (
      .clk_sys(clk_sys), .rst(rst), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .fault_in(fault_in), .out_cfg(out_cfg), .irq(irq));

   always #25 clk_sys = ~clk_sys;

   function automatic logic [31:0] xs(logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction

   // Event i: 0..5 stepdown 1..6, 6..8 linear 1..3, 9 supply good loss
   function automatic logic [9:0] evt_vec(int i);
      if (i < 6) return 10'h010 << i;
      if (i < 9) return 10'h002 << (i - 6);
      return 10'h001;
   endfunction

   function automatic logic [7:0] evt_addr(int i);
      return (i < 6) ? `OFS_FAULT_ONE : `OFS_FAULT_TWO;
   endfunction

   function automatic logic [31:0] evt_bit(int i);
      if (i < 6) return 32'h1 << i;
      if (i < 9) return 32'h1 << (i - 6);
      return 32'h8;
   endfunction

   task automatic close_out();
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic chk(logic [31:0] seen, logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // One APB transfer; request held until pready is sampled high
   task automatic apb(logic w, logic [7:0] a, logic [31:0] d, logic [3:0] s);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge clk_sys);
      penable <= 1'b1;
      for (n = 0; n < 20; n++) begin
         @(posedge clk_sys);
         if (pready === 1'b1) break;
      end
      if (n == 20) begin
         miscompares++;
         close_out();
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Fault events held over a transfer end with it
      fault_in <= '0;
      @(posedge clk_sys);
   endtask

   task automatic wr(logic [7:0] a, logic [31:0] d);
      apb(1'b1, a, d, 4'hF);
   endtask

   task automatic rdc(logic [7:0] a, logic [31:0] exp);
      apb(1'b0, a, xs(seed_q), 4'h0);
      chk(rd, exp);
      chk({31'h0, er}, 32'h0);
   endtask

   initial begin
      clk_sys = 1'b0;
      rst = 1'b1;
      ce = 1'b1;
      {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
      fault_in = '0;
      seed_q = 32'hD416;
      repeat (16) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      for (int a = 0; a <= 16; a += 4) rdc(8'(a), 32'h0);
      chk({24'h0, out_cfg, irq}, 32'h0);
      $display("test reset values done");
      for (int c = 0; c < 4; c++) begin
         v = {25'h0, 1'(c), 2'(c), 2'(3 - c), 2'(c)};
         wr(`OFS_OUTPUT_CTRL, v);
         rdc(`OFS_OUTPUT_CTRL, v);
         chk({25'h0, out_cfg}, v);
      end
      for (int k = 0; k < 8; k++) begin
         seed_q = xs(seed_q);
         wr(`OFS_OUTPUT_CTRL, seed_q);
         rdc(`OFS_OUTPUT_CTRL, seed_q & 32'h7F);
         chk({25'h0, out_cfg}, seed_q & 32'h7F);
      end
      apb(1'b1, `OFS_OUTPUT_CTRL, ~seed_q, 4'hE);
      rdc(`OFS_OUTPUT_CTRL, seed_q & 32'h7F);
      $display("test output control done");
      for (int i = 0; i < 10; i++) begin
         fault_in <= evt_vec(i);
         @(posedge clk_sys);
         fault_in <= '0;
         @(posedge clk_sys);
         rdc(evt_addr(i), evt_bit(i));
         chk({31'h0, irq}, 32'h0);
         wr(evt_addr(i) + 8'h08, evt_bit(i));
         chk({31'h0, irq}, 32'h1);
         wr(evt_addr(i), ~evt_bit(i));
         rdc(evt_addr(i), evt_bit(i));
         fault_in <= evt_vec(i);
         wr(evt_addr(i), evt_bit(i));
         fault_in <= '0;
         rdc(evt_addr(i), evt_bit(i));
         wr(evt_addr(i), evt_bit(i));
         rdc(evt_addr(i), 32'h0);
         chk({31'h0, irq}, 32'h0);
         wr(evt_addr(i) + 8'h08, 32'h0);
      end
      $display("test sticky flags done");
      apb(1'b0, 8'h14, 32'h0, 4'hF);
      chk(rd, 32'h0);
      chk({31'h0, er}, 32'h1);
      apb(1'b1, 8'h14, 32'hFF, 4'hF);
      chk({31'h0, er}, 32'h1);
      rdc(`OFS_OUTPUT_CTRL, seed_q & 32'h7F);
      $display("test unmapped access done");
      // Clock enable dropped in the ready cycle, with faults pending
      fork
         wr(`OFS_OUTPUT_CTRL, 32'h5A);
         begin
            repeat (2) @(posedge clk_sys);
            ce <= 1'b0;
            fault_in <= '1;
            repeat (2) @(posedge clk_sys);
            ce <= 1'b1;
            fault_in <= '0;
         end
      join
      rdc(`OFS_OUTPUT_CTRL, 32'h5A);
      rdc(`OFS_FAULT_ONE, 32'h0);
      rdc(`OFS_FAULT_TWO, 32'h0);
      $display("test clock enable done");
      fault_in <= '1;
      wr(`OFS_MASK_ONE, 32'h3F);
      chk({31'h0, irq}, 32'h1);
      rst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      chk({24'h0, out_cfg, irq}, 32'h0);
      rdc(`OFS_FAULT_ONE, 32'h0);
      rdc(`OFS_MASK_ONE, 32'h0);
      $display("test mid-run reset done");
      close_out();
   end
endmodule
